// *** design/gie_intercept.sv ***
// Guest intercept exit decision and exit information builder
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Origin bit zero: internal trap or external
// - I/O description high, pointer second word
// - Non-I/O extra fields undefined, consumers ignore
// - Config lock ignores system-management intercept
// - Port, breakpoints, trap flag, direction fields
// - Valid bit only during I/O instruction
// - Segment, address size, operand, repeat, string
// - Intercepted external interrupt exits, stays pending
// - Interrupts never hit exception intercepts
// - Block NMI and SYSMGMT_INTERRUPT after set-flag
// - Virtual interrupt exit leaves it pending
// - Task switch checked after validity, before change
// - Task switch consults single intercept bit
// - Selector first word, error code second
// - Return, far jump, error code flag bits
// - Resume flag into second word bit
// - Freeze intercept on legacy numeric error
// - Shutdown becomes guest exit
// - Load count on entry, decrement, exit zero
// - Zero count exits every pause except one after a long gap
// - Threshold reload or decrement, exit below zero
// - Zero threshold means simple count mode
module gie_intercept
  import gie_pkg::*;
(
  // Clock and reset
  input  wire logic          clock_i,
  input  wire logic          arst_n_i,
  // Guest control
  input  wire logic          guest_running_i,
  input  wire logic          guest_entry_i,
  input  wire gie_icpt_t     icpt_i,
  input  wire logic [15:0]   pause_count_i,
  input  wire logic [15:0]   pause_threshold_i,
  input  wire logic          threshold_supported_i,
  // Hardware configuration register bit
  input  wire logic          sysmgmt_config_lock_i,
  // Interrupt sources
  input  wire logic          maskable_irq_line_i,
  input  wire logic          nmi_i,
  input  wire logic          sysmgmt_interrupt_i,
  input  wire logic          sysmgmt_irq_origin_i,
  input  wire logic          virq_accept_i,
  input  wire logic          set_interrupt_flag_i,
  input  wire logic          insn_retire_i,
  // I/O instruction in flight
  input  wire logic          io_active_i,
  input  wire gie_io_desc_t  io_desc_i,
  // Task switch
  input  wire logic          task_sw_checked_i,
  input  wire gie_task_sw_t  task_sw_i,
  // Numeric error freeze
  input  wire logic          fp_error_i,
  input  wire logic          ignore_numeric_error_i,
  input  wire logic          numeric_error_mode_i,
  // Shutdown and pause
  input  wire logic          shutdown_i,
  input  wire logic          pause_i,
  // Results
  output gie_exit_rec_t      exit_o,
  output logic               irq_keep_pending_o,
  output logic               virq_keep_pending_o,
  output logic               task_sw_hold_o,
  output logic               guest_state_undefined_o
);

  logic          irq_shadow;
  logic          pause_exit;
  gie_exit_rec_t next_exit;
  logic [63:0]   smi_word1;
  logic [63:0]   smi_word2;
  logic [63:0]   ts_word1;
  logic [63:0]   ts_word2;
  logic          undef_flag;

  gie_pause_filter u_pause (
    .clock_i              (clock_i),
    .arst_n_i             (arst_n_i),
    .guest_entry_i        (guest_entry_i),
    .pause_count_i        (pause_count_i),
    .pause_threshold_i    (pause_threshold_i),
    .threshold_supported_i(threshold_supported_i),
    .pause_i              (pause_i && guest_running_i),
    .pause_icpt_i         (icpt_i.pause),
    .exit_o               (pause_exit)
  );

  // Event qualification. Interrupts route only through these intercepts,
  // never through exception intercepts, whatever their vector.
  wire hit_maskable_irq_line = icpt_i.maskable_irq_line && maskable_irq_line_i;
  wire hit_nmi  = icpt_i.nmi && nmi_i && !irq_shadow;
  wire hit_smi  = icpt_i.sysmgmt_interrupt && sysmgmt_interrupt_i
                  && !sysmgmt_config_lock_i
                  && !irq_shadow;
  wire hit_virq = icpt_i.virq && virq_accept_i;
  // Strobe arrives after validity checks; one enable covers all writes
  wire hit_ts   = icpt_i.task_sw && task_sw_checked_i;
  wire frozen   = fp_error_i && !ignore_numeric_error_i
                  && !numeric_error_mode_i;
  wire hit_frz  = icpt_i.freeze && frozen;
  wire hit_shut = icpt_i.shutdown && shutdown_i;

  wire any_hit  = guest_running_i && (hit_maskable_irq_line || hit_nmi || hit_smi
                  || hit_virq || hit_ts || hit_frz || hit_shut || pause_exit);

  // Interrupt-side pending hints: the source is never consumed on exit
  assign irq_keep_pending_o  = guest_running_i && hit_maskable_irq_line;
  assign virq_keep_pending_o = guest_running_i && hit_virq;
  // Hold the task switch from updating state while it is intercepted
  assign task_sw_hold_o      = guest_running_i && hit_ts;

  // System-management exit words
  always_comb begin
    smi_word1 = EXIT_INFO_RESET;
    smi_word2 = EXIT_INFO_RESET;
    smi_word1[SM_ORIGIN_BIT] = sysmgmt_irq_origin_i;
    if (io_active_i) begin
      smi_word1[SM_PORT_LO +: 16] = io_desc_i.port;
      smi_word1[SM_BRP_LO +: 4]   = io_desc_i.io_breakpoint_matches;
      smi_word1[SM_TF_BIT]        = io_desc_i.trap_flag_copy;
      smi_word1[SM_DIR_BIT]       = io_desc_i.is_input;
      smi_word1[SM_ADSZ_LO +: 3]  = {io_desc_i.addr_size_sixtyfour,
                                     io_desc_i.addr_size_thirtytwo,
                                     io_desc_i.addr_size_sixteen};
      smi_word1[SM_OPSZ_LO +: 3]  = {io_desc_i.opsize_thirtytwo,
                                     io_desc_i.opsize_sixteen,
                                     io_desc_i.opsize_eight};
      smi_word1[SM_REP_BIT]       = io_desc_i.repeat_prefix;
      smi_word1[SM_STR_BIT]       = io_desc_i.string_access;
      smi_word1[SM_SEG_LO +: 3]   = io_desc_i.effective_segment;
      smi_word1[SM_VALID_BIT]     = 1'b1;
      smi_word2                   = io_desc_i.rip;
    end
    // Otherwise extra fields read zero; hypervisor must not rely on them
  end

  // Task switch exit words
  always_comb begin
    ts_word1 = EXIT_INFO_RESET;
    ts_word2 = EXIT_INFO_RESET;
    ts_word1[TS_SEL_LO +: 16] = task_sw_i.task_state_segment;
    if (task_sw_i.has_error)
      ts_word2[TS_ERR_LO +: 32] = task_sw_i.error_code;
    ts_word2[TS_INTERRUPT_RETURN_BIT]    = task_sw_i.interrupt_return;
    ts_word2[TS_FARJMP_BIT]  = task_sw_i.far_jump;
    ts_word2[TS_HAS_ERR_BIT] = task_sw_i.has_error;
    ts_word2[TS_RF_BIT]      = task_sw_i.resume_flag_copy;
  end

  // Fixed priority when several events coincide
  always_comb begin
    next_exit = '0;
    next_exit.reason = GIE_EXIT_NONE;
    if (any_hit) begin
      next_exit.valid = 1'b1;
      if (hit_shut) begin
        next_exit.reason = GIE_EXIT_SHUTDOWN;
      end else if (hit_ts) begin
        next_exit.reason           = GIE_EXIT_TASKSW;
        next_exit.exit_info_first  = ts_word1;
        next_exit.exit_info_second = ts_word2;
      end else if (hit_smi) begin
        next_exit.reason           = GIE_EXIT_SMI;
        next_exit.exit_info_first  = smi_word1;
        next_exit.exit_info_second = smi_word2;
      end else if (hit_nmi) begin
        next_exit.reason = GIE_EXIT_NMI;
      end else if (hit_maskable_irq_line) begin
        next_exit.reason = GIE_EXIT_MASKABLE_IRQ_LINE;
      end else if (hit_frz) begin
        next_exit.reason = GIE_EXIT_FREEZE;
      end else if (hit_virq) begin
        next_exit.reason = GIE_EXIT_VIRQ;
      end else begin
        next_exit.pause_exit = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      exit_o     <= '0;
      irq_shadow <= 1'b0;
      undef_flag <= 1'b0;
    end else begin
      exit_o <= next_exit;
      // Shadow lasts until the next instruction retires
      if (set_interrupt_flag_i)
        irq_shadow <= 1'b1;
      else if (insn_retire_i)
        irq_shadow <= 1'b0;
      // A shutdown exit in the same cycle as an entry keeps the flag set
      if (any_hit && hit_shut)
        undef_flag <= 1'b1;
      else if (guest_entry_i)
        undef_flag <= 1'b0;
    end
  end

  assign guest_state_undefined_o = undef_flag;

endmodule : gie_intercept
`default_nettype wire

// *** design/gie_pause_filter.sv ***
// Pause filter counter with optional cycle threshold
`timescale 1ns/1ps
`default_nettype none
module gie_pause_filter
  import gie_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // Guest entry load
  input  wire logic        guest_entry_i,
  input  wire logic [15:0] pause_count_i,
  input  wire logic [15:0] pause_threshold_i,
  input  wire logic        threshold_supported_i,
  // Pause events
  input  wire logic        pause_i,
  input  wire logic        pause_icpt_i,
  output logic             exit_o
);

  logic [15:0] load_count;
  logic [15:0] load_thresh;
  logic [15:0] count;
  logic        neg;
  logic [15:0] elapsed;
  logic [15:0] next_count;
  logic        next_neg;

  wire adv_mode = threshold_supported_i && (load_thresh != PAUSE_RESET);
  wire long_gap = adv_mode && (elapsed > load_thresh);
  wire at_zero  = (count == PAUSE_RESET);

  // Simple mode exits when counter already zero; advanced on going below zero
  wire simple_exit = !adv_mode && at_zero;
  wire adv_exit    = adv_mode && !long_gap && (at_zero || neg);
  assign exit_o = pause_i && pause_icpt_i && (simple_exit || adv_exit);

  always_comb begin
    next_count = count;
    next_neg   = neg;
    if (pause_i) begin
      if (long_gap) begin
        next_count = load_count;
        next_neg   = 1'b0;
      end else if (!at_zero) begin
        next_count = count - 16'h1;
      end else if (adv_mode) begin
        next_neg = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      load_count  <= PAUSE_RESET;
      load_thresh <= PAUSE_RESET;
      count       <= PAUSE_RESET;
      neg         <= 1'b0;
      elapsed     <= PAUSE_RESET;
    end else if (guest_entry_i) begin
      load_count  <= pause_count_i;
      load_thresh <= pause_threshold_i;
      count       <= pause_count_i;
      neg         <= 1'b0;
      elapsed     <= PAUSE_RESET;
    end else begin
      count   <= next_count;
      neg     <= next_neg;
      // Saturate so a long idle spell still reads as a long gap
      if (pause_i)
        elapsed <= PAUSE_RESET;
      else if (elapsed != ELAPSED_MAX)
        elapsed <= elapsed + 16'h1;
    end
  end

endmodule : gie_pause_filter
`default_nettype wire

// *** design/gie_pkg.sv ***
// Shared constants and carrier types for the guest intercept exit logic
package gie_pkg;

  // First exit word, system-management intercept layout
  localparam int SM_ORIGIN_BIT     = 0;
  localparam int SM_SEG_LO         = 10;
  localparam int SM_DIR_BIT        = 32;
  localparam int SM_VALID_BIT      = 33;
  localparam int SM_STR_BIT        = 34;
  localparam int SM_REP_BIT        = 35;
  localparam int SM_OPSZ_LO        = 36;
  localparam int SM_ADSZ_LO        = 39;
  localparam int SM_TF_BIT         = 43;
  localparam int SM_BRP_LO         = 44;
  localparam int SM_PORT_LO        = 48;
  // Task switch layout
  localparam int TS_SEL_LO         = 0;
  localparam int TS_ERR_LO         = 0;
  localparam int TS_INTERRUPT_RETURN_BIT       = 36;
  localparam int TS_FARJMP_BIT     = 38;
  localparam int TS_HAS_ERR_BIT    = 44;
  localparam int TS_RF_BIT         = 48;

  localparam logic [63:0] EXIT_INFO_RESET = 64'h0;
  localparam logic [15:0] PAUSE_RESET     = 16'h0;
  localparam logic [15:0] ELAPSED_MAX     = 16'hffff;

  // Exit reasons reported with the exit pulse
  typedef enum logic [2:0] {
    GIE_EXIT_NONE     = 3'b000,
    GIE_EXIT_MASKABLE_IRQ_LINE     = 3'b001,
    GIE_EXIT_NMI      = 3'b010,
    GIE_EXIT_SMI      = 3'b011,
    GIE_EXIT_VIRQ     = 3'b100,
    GIE_EXIT_TASKSW   = 3'b101,
    GIE_EXIT_FREEZE   = 3'b110,
    GIE_EXIT_SHUTDOWN = 3'b111
  } gie_exit_t;

  typedef enum logic [2:0] {
    GIE_EXIT2_PAUSE = 3'b000
  } gie_unused_t;

  // Description of an I/O instruction in flight
  typedef struct packed {
    logic [15:0] port;
    logic [3:0]  io_breakpoint_matches;
    logic        trap_flag_copy;
    logic        addr_size_sixtyfour;
    logic        addr_size_thirtytwo;
    logic        addr_size_sixteen;
    logic        opsize_thirtytwo;
    logic        opsize_sixteen;
    logic        opsize_eight;
    logic        repeat_prefix;
    logic        string_access;
    logic        is_input;
    logic [2:0]  effective_segment;
    logic [63:0] rip;
  } gie_io_desc_t;

  // Task switch event details
  typedef struct packed {
    logic [15:0] task_state_segment;
    logic [31:0] error_code;
    logic        has_error;
    logic        interrupt_return;
    logic        far_jump;
    logic        resume_flag_copy;
  } gie_task_sw_t;

  // Intercept enables taken from the guest control block
  typedef struct packed {
    logic maskable_irq_line;
    logic nmi;
    logic sysmgmt_interrupt;
    logic virq;
    logic task_sw;
    logic freeze;
    logic shutdown;
    logic pause;
  } gie_icpt_t;

  // Exit result bundle
  typedef struct packed {
    logic        valid;
    gie_exit_t   reason;
    logic        pause_exit;
    logic [63:0] exit_info_first;
    logic [63:0] exit_info_second;
  } gie_exit_rec_t;

endpackage : gie_pkg

// *** verification/gie_chk.sv ***
// Port assertions for the guest intercept exit logic
`timescale 1ns/1ps
`default_nettype none
module gie_chk
  import gie_pkg::*;
(
  // Clock, reset and causes
  input wire logic          clock_i,
  input wire logic          arst_n_i,
  input wire logic          guest_running_i,
  input wire gie_icpt_t     icpt_i,
  input wire logic          sysmgmt_config_lock_i,
  input wire logic          sysmgmt_irq_origin_i,
  input wire logic          shutdown_i,
  input wire logic          io_active_i,
  input wire gie_io_desc_t  io_desc_i,
  input wire gie_task_sw_t  task_sw_i,
  // Results
  input wire gie_exit_rec_t exit_o,
  input wire logic          guest_state_undefined_o
);
  gie_io_desc_t io_q;
  gie_task_sw_t ts_q;
  wire sm = exit_o.valid && exit_o.reason == GIE_EXIT_SMI;
  wire tx = exit_o.valid && exit_o.reason == GIE_EXIT_TASKSW;
  wire [63:0] w1 = exit_o.exit_info_first;
  wire [63:0] w2 = exit_o.exit_info_second;
  // Copies of the event details seen one edge before the exit record
  always_ff @(posedge clock_i) begin
    io_q <= io_desc_i;
    ts_q <= task_sw_i;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  smi_lock_a:
    assert property (sm |-> !$past(sysmgmt_config_lock_i))
    else $error("exit taken while lock set");
  smi_origin_a:
    assert property (sm |-> w1[0] == $past(sysmgmt_irq_origin_i))
    else $error("origin bit wrong");
  io_valid_a:
    assert property (sm |-> w1[33] == $past(io_active_i))
    else $error("io valid bit wrong");
  io_rip_a:
    assert property (sm && w1[33] |-> w2 == io_q.rip)
    else $error("io pointer wrong");
  io_port_a:
    assert property (sm && w1[33] |->
      w1[63:43] == io_q[96:76] && w1[32] == io_q.is_input)
    else $error("port fields wrong");
  io_sizes_a:
    assert property (sm && w1[33] |->
      w1[12:10] == io_q.effective_segment && w1[41:34] == io_q[75:68])
    else $error("size fields wrong");
  task_info_a:
    assert property (tx |-> w1[15:0] == ts_q.task_state_segment &&
      w2[48] == ts_q.resume_flag_copy && w2[44] == ts_q.has_error &&
      w2[38] == ts_q.far_jump && w2[36] == ts_q.interrupt_return)
    else $error("task switch info wrong");
  shutdown_exit_a:
    assert property (guest_running_i && icpt_i.shutdown && shutdown_i |=>
      exit_o.valid && exit_o.reason == GIE_EXIT_SHUTDOWN
      ##1 guest_state_undefined_o)
    else $error("shutdown not turned into exit");
  cover property (sm && w1[33]);
  cover property (tx);
  cover property (exit_o.valid && exit_o.pause_exit);
endmodule : gie_chk
bind gie_intercept gie_chk u_chk (
  .clock_i(clock_i), .arst_n_i(arst_n_i),
  .guest_running_i(guest_running_i), .icpt_i(icpt_i),
  .sysmgmt_config_lock_i(sysmgmt_config_lock_i),
  .sysmgmt_irq_origin_i(sysmgmt_irq_origin_i), .shutdown_i(shutdown_i),
  .io_active_i(io_active_i), .io_desc_i(io_desc_i),
  .task_sw_i(task_sw_i), .exit_o(exit_o),
  .guest_state_undefined_o(guest_state_undefined_o)
);
`default_nettype wire

// *** verification/gie_hv_model.sv ***
// Hypervisor side model that reads guest exit records
`timescale 1ns/1ps
`default_nettype none
module gie_hv_model
  import gie_pkg::*;
(
  // Clock and reset
  input  wire logic          clock_i,
  input  wire logic          arst_n_i,
  // Exit records
  input  wire gie_exit_rec_t exit_i,
  output logic [63:0]        io_rip_o
);
  // Pointer word trusted only when the I/O description is marked valid
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      io_rip_o <= 64'h0;
    end else if (exit_i.valid && exit_i.reason == GIE_EXIT_SMI &&
                 exit_i.exit_info_first[33]) begin
      io_rip_o <= exit_i.exit_info_second;
    end
  end
endmodule : gie_hv_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking testbench for the guest intercept exit logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gie_pkg::*;
  localparam logic [5:0] RUN = 6'h01;
  logic          clock_i = 1'b0;
  logic          arst_n_i = 1'b0;
  // Pulses: smi irq nmi virq tsw fpe shd pause entry sti retire
  logic [10:0]   ev = '0;
  // Levels: running io_active origin lock ignore_ne ne_mode
  logic [5:0]    ctl = RUN;
  logic [15:0]   pcnt = '0;
  logic [15:0]   pthr = '0;
  logic          sup = 1'b1;
  gie_icpt_t     icpt = 8'hff;
  gie_io_desc_t  io = {16'h03f8, 4'ha, 1'b1, 6'b010_010, 3'b101, 3'h5,
                       64'h1234_5678_9abc_def0};
  gie_task_sw_t  ts = {16'h0028, 32'h0000_0abc, 4'b1011};
  gie_exit_rec_t ex;
  logic          ikp, vkp, tsh, und;
  logic [63:0]   rip;
  logic [2:0]    hk;
  int            errors = 0;
  int            check_count = 0;

  gie_intercept dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .guest_running_i(ctl[0]),
    .guest_entry_i(ev[8]), .icpt_i(icpt), .pause_count_i(pcnt),
    .pause_threshold_i(pthr), .threshold_supported_i(sup),
    .sysmgmt_config_lock_i(ctl[3]), .maskable_irq_line_i(ev[1]),
    .nmi_i(ev[2]), .sysmgmt_interrupt_i(ev[0]),
    .sysmgmt_irq_origin_i(ctl[2]), .virq_accept_i(ev[3]),
    .set_interrupt_flag_i(ev[9]), .insn_retire_i(ev[10]),
    .io_active_i(ctl[1]), .io_desc_i(io), .task_sw_checked_i(ev[4]),
    .task_sw_i(ts), .fp_error_i(ev[5]), .ignore_numeric_error_i(ctl[4]),
    .numeric_error_mode_i(ctl[5]), .shutdown_i(ev[6]), .pause_i(ev[7]),
    .exit_o(ex), .irq_keep_pending_o(ikp), .virq_keep_pending_o(vkp),
    .task_sw_hold_o(tsh), .guest_state_undefined_o(und));
  gie_hv_model hv (.clock_i(clock_i), .arst_n_i(arst_n_i), .exit_i(ex),
    .io_rip_o(rip));

  initial begin
    forever #20 clock_i = ~clock_i;
  end

  task automatic chk(input string n, input logic [63:0] e, g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One event for one cycle; hints sampled before the taking edge
  task automatic fire(input logic [10:0] e, input logic [5:0] c);
    @(posedge clock_i);
    ev <= e;
    ctl <= c;
    #1 hk = {ikp, vkp, tsh};
    @(posedge clock_i);
    ev <= '0;
    #1;
  endtask : fire

  task automatic ok(input gie_exit_t r);
    chk("exit", 64'({1'b1, r}), 64'({ex.valid, ex.reason}));
  endtask : ok

  task automatic t_smi;
    logic [63:0] w;
    w = {io[96:76], 1'b0, io[75:68], 1'b1, io[67], 19'h0, io[66:64],
         9'h0, 1'b1};
    fire(11'h001, 6'h07);
    ok(GIE_EXIT_SMI);
    chk("word1", w, ex.exit_info_first);
    chk("word2", io.rip, ex.exit_info_second);
    fire(11'h001, RUN);
    ok(GIE_EXIT_SMI);
    chk("no io valid", 64'h0, 64'(ex.exit_info_first[33]));
    chk("origin int", 64'h0, 64'(ex.exit_info_first[0]));
    chk("hv rip", io.rip, rip);
    $display("smi test done");
  endtask : t_smi

  task automatic t_block;
    fire(11'h001, 6'h09);
    chk("locked", 64'h0, 64'(ex.valid));
    fire(11'h002, 6'h00);
    chk("stopped", 64'h0, 64'(ex.valid));
    @(posedge clock_i);
    icpt <= 8'h7f;
    fire(11'h002, RUN);
    chk("maskable_irq_line off", 64'h0, 64'(ex.valid));
    @(posedge clock_i);
    icpt <= 8'hff;
    fire(11'h200, RUN);
    fire(11'h004, RUN);
    chk("shadow", 64'h0, 64'(ex.valid));
    fire(11'h400, RUN);
    fire(11'h004, RUN);
    ok(GIE_EXIT_NMI);
    $display("block test done");
  endtask : t_block

  task automatic t_evt;
    fire(11'h002, RUN);
    chk("irq hint", 64'h4, 64'(hk));
    ok(GIE_EXIT_MASKABLE_IRQ_LINE);
    fire(11'h008, RUN);
    chk("virq hint", 64'h2, 64'(hk));
    ok(GIE_EXIT_VIRQ);
    fire(11'h010, RUN);
    chk("ts hold", 64'h1, 64'(hk));
    ok(GIE_EXIT_TASKSW);
    chk("ts sel", 64'(ts.task_state_segment),
      64'(ex.exit_info_first[15:0]));
    chk("ts word2", {15'h0, ts.resume_flag_copy, 3'h0, ts.has_error, 5'h0,
      ts.far_jump, 1'b0, ts.interrupt_return, 4'h0, ts.error_code},
      ex.exit_info_second);
    fire(11'h020, 6'h11);
    chk("fp ignored", 64'h0, 64'(ex.valid));
    fire(11'h020, 6'h21);
    chk("fp native", 64'h0, 64'(ex.valid));
    fire(11'h020, RUN);
    ok(GIE_EXIT_FREEZE);
    fire(11'h040, RUN);
    ok(GIE_EXIT_SHUTDOWN);
    @(posedge clock_i);
    #1 chk("undef set", 64'h1, 64'(und));
    fire(11'h100, RUN);
    chk("undef clear", 64'h0, 64'(und));
    $display("event test done");
  endtask : t_evt

  task automatic pz(input logic [15:0] c, t, input int gap,
                    input logic [2:0] m);
    logic [2:0] s;
    @(posedge clock_i);
    pcnt <= c;
    pthr <= t;
    fire(11'h100, RUN);
    for (int i = 0; i < 3; i++) begin
      fire(11'h080, RUN);
      s[i] = ex.pause_exit;
      repeat (gap) @(posedge clock_i);
    end
    chk("pause exits", 64'(m), 64'(s));
    $display("pause test done");
  endtask : pz

  task automatic conclude;
    $display("Checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  initial begin
    repeat (3000) @(posedge clock_i);
    errors++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_smi();
    t_block();
    t_evt();
    pz(16'h2, 16'h0, 0, 3'b100);
    pz(16'h0, 16'h0, 0, 3'b111);
    pz(16'h1, 16'h4, 0, 3'b110);
    pz(16'h1, 16'h4, 8, 3'b000);
    pz(16'h1, 16'h9, 8, 3'b110);
    // Without advanced support the threshold must be ignored
    @(posedge clock_i);
    sup <= 1'b0;
    pz(16'h1, 16'h4, 8, 3'b110);
    conclude();
  end
endmodule : tb
`default_nettype wire
